// ### rtl/sli_pkg.sv
package sli_pkg;
  localparam int          ADDR_W           = 12;
  localparam int          DATA_W           = 8;
  localparam int          LIMIT_W          = 8;
  localparam logic [11:0] OFS_DISP_LANES   = 12'h46d;
  localparam logic [11:0] OFS_INV_LANES    = 12'h46e;
  localparam logic [11:0] OFS_STRAY_LANES  = 12'h46f;
  localparam logic [11:0] OFS_SYMBOL_LOCK  = 12'h470;
  localparam logic [11:0] OFS_FRAME_LOCK   = 12'h471;
  localparam logic [11:0] OFS_CHECKSUM     = 12'h472;
  localparam logic [11:0] OFS_ALIGN_STATUS = 12'h473;
  localparam logic [11:0] OFS_OCTETS       = 12'h476;
  localparam logic [11:0] OFS_TEST_CTRL    = 12'h477;
  localparam logic [11:0] OFS_MULTIFRAME   = 12'h478;
  localparam logic [11:0] OFS_IRQ_VECTOR   = 12'h47a;
  localparam logic [11:0] OFS_LIMIT        = 12'h47c;
  localparam int          BIT_IRQ_CLEAR    = 7;
  localparam int          BIT_CNT_CLEAR    = 5;
  localparam int          LANE_SEL_W       = 3;
  localparam int          BIT_TEST_MODE    = 7;
  localparam int          BIT_THRESH_EN    = 3;
  localparam int          VEC_DISP         = 7;
  localparam int          VEC_INV          = 6;
  localparam int          VEC_STRAY        = 5;
  localparam int          VEC_ALIGN        = 3;
  localparam int          VEC_CHECKSUM     = 2;
  localparam int          VEC_FRAME        = 1;
  localparam int          VEC_SYMBOL       = 0;
  localparam logic [7:0]  TEST_CTRL_MASK   = 8'h88;
  localparam logic [7:0]  RST_OCTETS       = 8'h01;
  localparam logic [7:0]  RST_TEST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_MULTIFRAME   = 8'h01;
  localparam logic [7:0]  RST_ENABLE       = 8'h00;
  localparam logic [7:0]  RST_LIMIT        = 8'hff;
  localparam int          NUM_CLASSES      = 3;
  typedef enum logic [1:0] {CLS_DISP = 2'h0, CLS_INV = 2'h1, CLS_STRAY = 2'h2} sli_cls_e;
endpackage

// ### rtl/sli_cnt_if.sv
`timescale 1ns/10ps
interface sli_cnt_if #(
  parameter int N = 24
);
  logic [N-1:0]             eventPulse;
  logic [N-1:0]             clearCount;
  logic [N-1:0]             reached;
  logic [sli_pkg::LIMIT_W-1:0] limit;
  modport ctrl (output eventPulse, output clearCount, output limit, input reached);
  modport cnt  (input eventPulse, input clearCount, input limit, output reached);
endinterface

// ### rtl/sli_err_counters.sv
`timescale 1ns/10ps
module sli_err_counters #(
  parameter int N = 24
) (
  input wire logic  sys_clk,
  input wire logic  rst,
  sli_cnt_if.cnt    cntIf
);
  import sli_pkg::*;

  generate
    if (N < 1) begin : g_bad
      $error("sli_err_counters needs at least one counter");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cnt
      logic [LIMIT_W-1:0] count_q;
      // Counter holds at the limit so a long error burst cannot wrap past it
      always_ff @(posedge sys_clk) begin
        if (rst || cntIf.clearCount[i]) begin
          count_q <= '0;
        end else if (cntIf.eventPulse[i] && (count_q < cntIf.limit)) begin
          count_q <= count_q + 8'h01;
        end
      end
      assign cntIf.reached[i] = (count_q >= cntIf.limit);
    end
  endgenerate
endmodule

// ### rtl/sli_link_status.sv
`timescale 1ns/10ps
module sli_link_status #(
  parameter int NUM_LANES = 8
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            regWrEn,
  input  wire logic                            regRdEn,
  input  wire logic [sli_pkg::ADDR_W-1:0]      regAddr,
  input  wire logic [sli_pkg::DATA_W-1:0]      regWrData,
  output logic      [sli_pkg::DATA_W-1:0]      regRdData,
  input  wire logic [NUM_LANES-1:0]            disparityErr,
  input  wire logic [NUM_LANES-1:0]            invalidSymbolErr,
  input  wire logic [NUM_LANES-1:0]            strayControlErr,
  input  wire logic [NUM_LANES-1:0]            symbolLock,
  input  wire logic [NUM_LANES-1:0]            frameLock,
  input  wire logic [NUM_LANES-1:0]            checksumGood,
  input  wire logic [NUM_LANES-1:0]            alignmentDone,
  output logic      [sli_pkg::DATA_W-1:0]      frameOctetCount,
  output logic                                 alignmentTestMode,
  output logic                                 thresholdMaskEnable,
  output logic      [sli_pkg::DATA_W-1:0]      alignmentMultiframesDiv4,
  output logic                                 irq_n,
  output logic                                 syncRequestOutA_n,
  output logic                                 syncRequestOutB_n
);
  import sli_pkg::*;

  localparam int NCNT = NUM_CLASSES * NUM_LANES;
  localparam int HALF = NUM_LANES / 2;

  generate
    if (NUM_LANES < 2 || NUM_LANES > 8) begin : g_bad
      $error("NUM_LANES must lie between 2 and 8");
    end
  endgenerate

  logic [DATA_W-1:0]    octets_q;
  logic [DATA_W-1:0]    testCtrl_q;
  logic [DATA_W-1:0]    multiframe_q;
  logic [DATA_W-1:0]    enable_q;
  logic [LIMIT_W-1:0]   limit_q;
  logic [NUM_LANES-1:0] alignStatus_q;
  logic [NCNT-1:0]      reachedLatch_q;
  logic [3:0]           syncFail_q;
  logic [DATA_W-1:0]    vector;
  logic [DATA_W-1:0]    rdMux;
  logic [3:0]           syncFailNow;
  logic [3:0]           syncClearWr;
  logic [NUM_LANES-1:0] syncLostLane;
  logic                 irq_q;
  logic                 syncA_q;
  logic                 syncB_q;

  wire wrHit = regWrEn;
  wire [LANE_SEL_W-1:0] laneSel = regWrData[LANE_SEL_W-1:0];

  sli_cnt_if #(.N(NCNT)) cntIf ();

  sli_err_counters #(.N(NCNT)) u_counters (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cntIf   (cntIf)
  );

  assign cntIf.limit = limit_q;
  assign cntIf.eventPulse = {strayControlErr, invalidSymbolErr, disparityErr};

  // Per class lane write: bit7 clears the lane latch, bit5 restarts its counter
  genvar c, l;
  generate
    for (c = 0; c < NUM_CLASSES; c++) begin : g_cls
      for (l = 0; l < NUM_LANES; l++) begin : g_lane
        localparam int IDX = c * NUM_LANES + l;
        wire laneWr = wrHit && (regAddr == OFS_DISP_LANES + 12'(c)) && (laneSel == LANE_SEL_W'(l));
        assign cntIf.clearCount[IDX] = laneWr && regWrData[BIT_CNT_CLEAR];
        // Set wins over clear so a limit hit in the clear cycle is kept
        always_ff @(posedge sys_clk) begin
          if (rst) begin
            reachedLatch_q[IDX] <= 1'b0;
          end else if (cntIf.reached[IDX]) begin
            reachedLatch_q[IDX] <= 1'b1;
          end else if (laneWr && regWrData[BIT_IRQ_CLEAR]) begin
            reachedLatch_q[IDX] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Alignment status is registered each cycle, so reads, flag and sync request see the lane input one cycle late
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alignStatus_q <= '0;
    end else begin
      alignStatus_q <= alignmentDone;
    end
  end

  assign syncFailNow[VEC_ALIGN]    = ~&alignStatus_q;
  assign syncFailNow[VEC_CHECKSUM] = ~&checksumGood;
  assign syncFailNow[VEC_FRAME]    = ~&frameLock;
  assign syncFailNow[VEC_SYMBOL]   = ~&symbolLock;

  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : g_sync
      assign syncClearWr[s] = wrHit && regWrData[BIT_IRQ_CLEAR] && (regAddr == OFS_SYMBOL_LOCK + 12'(s));
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          syncFail_q[s] <= 1'b0;
        end else if (syncFailNow[s]) begin
          syncFail_q[s] <= 1'b1;
        end else if (syncClearWr[s]) begin
          syncFail_q[s] <= 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    vector               = '0;
    vector[VEC_DISP]     = |reachedLatch_q[NUM_LANES-1:0];
    vector[VEC_INV]      = |reachedLatch_q[2*NUM_LANES-1:NUM_LANES];
    vector[VEC_STRAY]    = |reachedLatch_q[3*NUM_LANES-1:2*NUM_LANES];
    vector[VEC_ALIGN]    = syncFail_q[VEC_ALIGN];
    vector[VEC_CHECKSUM] = syncFail_q[VEC_CHECKSUM];
    vector[VEC_FRAME]    = syncFail_q[VEC_FRAME];
    vector[VEC_SYMBOL]   = syncFail_q[VEC_SYMBOL];
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      octets_q     <= RST_OCTETS;
      testCtrl_q   <= RST_TEST_CTRL;
      multiframe_q <= RST_MULTIFRAME;
      enable_q     <= RST_ENABLE;
      limit_q      <= RST_LIMIT;
    end else if (wrHit) begin
      case (regAddr)
        OFS_OCTETS:     octets_q   <= regWrData;
        OFS_TEST_CTRL:  testCtrl_q <= regWrData & TEST_CTRL_MASK;
        OFS_MULTIFRAME: begin
          // A zero count would leave the alignment sequence empty
          if (regWrData != 8'h00) begin
            multiframe_q <= regWrData;
          end
        end
        OFS_IRQ_VECTOR: enable_q   <= regWrData & 8'hef;
        OFS_LIMIT:      limit_q    <= regWrData;
        default:        ;
      endcase
    end
  end

  assign frameOctetCount          = octets_q;
  assign alignmentTestMode        = testCtrl_q[BIT_TEST_MODE];
  assign thresholdMaskEnable      = testCtrl_q[BIT_THRESH_EN];
  assign alignmentMultiframesDiv4 = multiframe_q;

  // Read data; the enable register is write only, so that offset returns the flags
  always_comb begin
    rdMux = '0;
    case (regAddr)
      OFS_DISP_LANES:   rdMux[NUM_LANES-1:0] = reachedLatch_q[NUM_LANES-1:0];
      OFS_INV_LANES:    rdMux[NUM_LANES-1:0] = reachedLatch_q[2*NUM_LANES-1:NUM_LANES];
      OFS_STRAY_LANES:  rdMux[NUM_LANES-1:0] = reachedLatch_q[3*NUM_LANES-1:2*NUM_LANES];
      OFS_SYMBOL_LOCK:  rdMux[NUM_LANES-1:0] = symbolLock;
      OFS_FRAME_LOCK:   rdMux[NUM_LANES-1:0] = frameLock;
      OFS_CHECKSUM:     rdMux[NUM_LANES-1:0] = checksumGood;
      OFS_ALIGN_STATUS: rdMux[NUM_LANES-1:0] = alignStatus_q;
      OFS_OCTETS:       rdMux = octets_q;
      OFS_TEST_CTRL:    rdMux = testCtrl_q;
      OFS_MULTIFRAME:   rdMux = multiframe_q;
      OFS_IRQ_VECTOR:   rdMux = vector;
      OFS_LIMIT:        rdMux = limit_q;
      default:          rdMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // Interrupt pin: level, low while any enabled flag stands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(vector & enable_q);
    end
  end
  assign irq_n = ~irq_q;

  // Sync request: lower half of the lanes on output A, upper half on B
  assign syncLostLane = ~alignStatus_q | ~symbolLock;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= |syncLostLane[HALF-1:0];
      syncB_q <= |syncLostLane[NUM_LANES-1:HALF];
    end
  end
  assign syncRequestOutA_n = ~syncA_q;
  assign syncRequestOutB_n = ~syncB_q;

  a_disp_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_DISP] && |cntIf.reached[NUM_LANES-1:0] |-> ##[1:2] !irq_n)
    else $error("disparity limit did not pull interrupt low");
  a_inv_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_INV] && vector[VEC_INV] |=> !irq_n)
    else $error("invalid symbol flag did not pull interrupt low");
  a_stray_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_STRAY] && |cntIf.reached[3*NUM_LANES-1:2*NUM_LANES] |-> ##2 !irq_n)
    else $error("stray control limit did not pull interrupt low");
  a_align_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_ALIGN] && !(&alignmentDone) |-> ##[2:3] !irq_n)
    else $error("alignment failure did not pull interrupt low");
  a_checksum_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_CHECKSUM] && !(&checksumGood) |-> ##2 !irq_n)
    else $error("bad checksum did not pull interrupt low");
  a_frame_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_FRAME] && !(&frameLock) |-> ##2 !irq_n)
    else $error("frame lock loss did not pull interrupt low");
  a_symbol_irq_low: assert property (@(posedge sys_clk) disable iff (rst)
    enable_q[VEC_SYMBOL] && !(&symbolLock) |-> ##2 !irq_n)
    else $error("symbol lock loss did not pull interrupt low");
  a_irq_release_high: assert property (@(posedge sys_clk) disable iff (rst)
    (vector & enable_q) == 8'h00 |=> irq_n)
    else $error("interrupt stayed low with no enabled flag");
  a_align_clear_works: assert property (@(posedge sys_clk) disable iff (rst)
    syncClearWr[VEC_ALIGN] && &alignStatus_q |=> !vector[VEC_ALIGN])
    else $error("alignment flag not cleared by bit 7 write");
  a_zero_count_kept: assert property (@(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == OFS_MULTIFRAME && regWrData == 8'h00 |=> $stable(alignmentMultiframesDiv4))
    else $error("zero multiframe count was accepted");
  a_align_sync_req: assert property (@(posedge sys_clk) disable iff (rst)
    !alignmentDone[0] |-> ##2 !syncRequestOutA_n)
    else $error("alignment loss gave no sync request");
  a_disp_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    |cntIf.reached[NUM_LANES-1:0] |=> vector[VEC_DISP] [*2])
    else $error("disparity flag missing after limit reached");
  a_inv_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(|cntIf.reached[2*NUM_LANES-1:NUM_LANES]) |=> vector[VEC_INV])
    else $error("invalid symbol flag missing after limit reached");
  a_limit_reset: assert property (@(posedge sys_clk) $fell(rst) |-> limit_q == RST_LIMIT)
    else $error("limit not at all ones after reset");
  a_vector_sync: assert property (@(posedge sys_clk) disable iff (rst)
    !(&frameLock) |=> vector[VEC_FRAME])
    else $error("frame sync flag missing");
  a_test_mode_out: assert property (@(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == OFS_TEST_CTRL |=> alignmentTestMode == $past(regWrData[BIT_TEST_MODE]))
    else $error("test mode output does not follow the control bit");
  a_octets_out: assert property (@(posedge sys_clk) $fell(rst) |-> frameOctetCount == RST_OCTETS)
    else $error("octets per frame not one after reset");
  a_upper_sync_req: assert property (@(posedge sys_clk) disable iff (rst)
    !alignmentDone[HALF] |-> ##2 !syncRequestOutB_n)
    else $error("upper lane alignment loss gave no sync request");
  a_symbol_sync_req: assert property (@(posedge sys_clk) disable iff (rst)
    !symbolLock[HALF] |=> !syncRequestOutB_n)
    else $error("symbol lock loss gave no sync request");
  a_stray_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    |cntIf.reached[3*NUM_LANES-1:2*NUM_LANES] |=> vector[VEC_STRAY])
    else $error("stray control flag missing after limit reached");
  a_checksum_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    !(&checksumGood) |=> vector[VEC_CHECKSUM])
    else $error("checksum flag missing");
  a_symbol_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    !(&symbolLock) |=> vector[VEC_SYMBOL])
    else $error("symbol lock flag missing");
  a_align_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    !(&alignStatus_q) |=> vector[VEC_ALIGN])
    else $error("alignment flag missing");

  c_irq_low: cover property (@(posedge sys_clk) disable iff (rst) $fell(irq_n));
  c_irq_cleared: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_n));
  c_sync_req_b: cover property (@(posedge sys_clk) disable iff (rst) !syncRequestOutB_n ##1 syncRequestOutB_n);
  c_sync_req_a: cover property (@(posedge sys_clk) disable iff (rst) $fell(syncRequestOutA_n));
  c_zero_refused: cover property (@(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == OFS_MULTIFRAME && regWrData == 8'h00);
endmodule

// ### sim/sli_tx_model.sv
`timescale 1ns/10ps
// Far-side transmitter: drives per-lane lock levels and error events.
// Lanes stay good until the bench tells a lane to fail.
module sli_tx_model #(
  parameter int N = 4
) (
  input  wire logic         sys_clk,
  output logic      [N-1:0] disparityErr,
  output logic      [N-1:0] invalidSymbolErr,
  output logic      [N-1:0] strayControlErr,
  output logic      [N-1:0] symbolLock,
  output logic      [N-1:0] frameLock,
  output logic      [N-1:0] checksumGood,
  output logic      [N-1:0] alignmentDone
);
  logic [3:0][N-1:0] lostLanes = '0;
  logic [2:0][N-1:0] errNow    = '0;

  assign disparityErr     = errNow[0];
  assign invalidSymbolErr = errNow[1];
  assign strayControlErr  = errNow[2];
  assign symbolLock       = ~lostLanes[0];
  assign frameLock        = ~lostLanes[1];
  assign checksumGood     = ~lostLanes[2];
  assign alignmentDone    = ~lostLanes[3];

  // One high cycle per event with a gap, so each is counted exactly once
  task automatic pulse(input int cls, input int lane, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      errNow[cls][lane] = 1'b1;
      @(negedge sys_clk);
      errNow[cls][lane] = 1'b0;
    end
  endtask

  task automatic setLost(input int k, input logic [N-1:0] m);
    @(negedge sys_clk);
    lostLanes[k] = m;
  endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sli_pkg::*;
  localparam int NL = 4;
  logic              sys_clk   = 1'b0;
  logic              rst       = 1'b1;
  logic              regWrEn   = 1'b0;
  logic              regRdEn   = 1'b0;
  logic [ADDR_W-1:0] regAddr   = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData, frameOctetCount, alignmentMultiframesDiv4;
  logic              alignmentTestMode, thresholdMaskEnable, irq_n, syncRequestOutA_n, syncRequestOutB_n;
  logic [NL-1:0]     disparityErr, invalidSymbolErr, strayControlErr;
  logic [NL-1:0]     symbolLock, frameLock, checksumGood, alignmentDone;
  int                badCount   = 0;
  int                checksDone = 0;
  logic [7:0]        octVals [3] = '{8'h01, 8'h02, 8'h04};

  always #25 sys_clk = ~sys_clk;

  sli_link_status #(.NUM_LANES(NL)) sli_link_status_inst (
    .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .disparityErr(disparityErr),
    .invalidSymbolErr(invalidSymbolErr), .strayControlErr(strayControlErr), .symbolLock(symbolLock),
    .frameLock(frameLock), .checksumGood(checksumGood), .alignmentDone(alignmentDone),
    .frameOctetCount(frameOctetCount), .alignmentTestMode(alignmentTestMode),
    .thresholdMaskEnable(thresholdMaskEnable), .alignmentMultiframesDiv4(alignmentMultiframesDiv4),
    .irq_n(irq_n), .syncRequestOutA_n(syncRequestOutA_n), .syncRequestOutB_n(syncRequestOutB_n));

  sli_tx_model #(.N(NL)) sli_tx_model_inst (
    .sys_clk(sys_clk), .disparityErr(disparityErr), .invalidSymbolErr(invalidSymbolErr),
    .strayControlErr(strayControlErr), .symbolLock(symbolLock), .frameLock(frameLock),
    .checksumGood(checksumGood), .alignmentDone(alignmentDone));

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask

  // Read data is registered: valid after the edge that takes the strobe
  task automatic checkReg(input logic [11:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    check(regRdData, exp);
  endtask

  task automatic waitIrq(input logic exp);
    int i;
    for (i = 0; i < 8 && irq_n !== exp; i++) @(negedge sys_clk);
    check({7'h00, irq_n}, {7'h00, exp});
    if (irq_n !== exp) reportAndStop();
  endtask

  initial begin
    #2000000;
    badCount++;
    reportAndStop();
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    checkReg(OFS_OCTETS, 8'h01);
    checkReg(OFS_TEST_CTRL, 8'h00);
    checkReg(OFS_MULTIFRAME, 8'h01);
    checkReg(OFS_LIMIT, 8'hff);
    check({7'h00, irq_n}, 8'h01);
    // Flags may be set from reset, before the lanes reported good
    for (int k = 0; k < 4; k++) wr(OFS_SYMBOL_LOCK + 12'(k), 8'h80);
    checkReg(OFS_IRQ_VECTOR, 8'h00);
    $display("test reset_values done");

    foreach (octVals[i]) begin
      wr(OFS_OCTETS, octVals[i]);
      checkReg(OFS_OCTETS, octVals[i]);
      check(frameOctetCount, octVals[i]);
    end
    wr(OFS_TEST_CTRL, 8'hff);
    checkReg(OFS_TEST_CTRL, 8'h88);
    check({6'h00, alignmentTestMode, thresholdMaskEnable}, 8'h03);
    wr(OFS_TEST_CTRL, 8'h00);
    check({6'h00, alignmentTestMode, thresholdMaskEnable}, 8'h00);
    wr(OFS_MULTIFRAME, 8'h03);
    wr(OFS_MULTIFRAME, 8'h00);
    checkReg(OFS_MULTIFRAME, 8'h03);
    check(alignmentMultiframesDiv4, 8'h03);
    wr(12'h479, 8'h5a);
    checkReg(12'h479, 8'h00);
    $display("test config_regs done");

    wr(OFS_LIMIT, 8'h03);
    for (int c = 0; c < 3; c++) begin
      wr(OFS_IRQ_VECTOR, 8'h80 >> c);
      sli_tx_model_inst.pulse(c, 1, 2);
      repeat (4) @(negedge sys_clk);
      check({7'h00, irq_n}, 8'h01);
      checkReg(OFS_IRQ_VECTOR, 8'h00);
      sli_tx_model_inst.pulse(c, 1, 1);
      waitIrq(1'b0);
      checkReg(OFS_IRQ_VECTOR, 8'h80 >> c);
      checkReg(OFS_DISP_LANES + 12'(c), 8'h02);
      // Counter first: a stuck-at-limit counter would re-set the flag
      wr(OFS_DISP_LANES + 12'(c), 8'h21);
      wr(OFS_DISP_LANES + 12'(c), 8'h81);
      waitIrq(1'b1);
      checkReg(OFS_IRQ_VECTOR, 8'h00);
    end
    $display("test error_limits done");

    for (int k = 0; k < 4; k++) begin
      wr(OFS_IRQ_VECTOR, 8'h01 << k);
      sli_tx_model_inst.setLost(k, 4'b0100);
      waitIrq(1'b0);
      checkReg(OFS_IRQ_VECTOR, 8'h01 << k);
      check({6'h00, syncRequestOutA_n, syncRequestOutB_n}, (k == 0 || k == 3) ? 8'h02 : 8'h03);
      checkReg(OFS_SYMBOL_LOCK + 12'(k), 8'h0b);
      sli_tx_model_inst.setLost(k, 4'b0000);
      repeat (2) @(negedge sys_clk);
      wr(OFS_SYMBOL_LOCK + 12'(k), 8'h80);
      waitIrq(1'b1);
      checkReg(OFS_IRQ_VECTOR, 8'h00);
      check({6'h00, syncRequestOutA_n, syncRequestOutB_n}, 8'h03);
    end
    // Lower lane lost: request must leave on output A only
    sli_tx_model_inst.setLost(3, 4'b0001);
    repeat (3) @(negedge sys_clk);
    check({6'h00, syncRequestOutA_n, syncRequestOutB_n}, 8'h01);
    checkReg(OFS_ALIGN_STATUS, 8'h0e);
    sli_tx_model_inst.setLost(3, 4'b0000);
    repeat (2) @(negedge sys_clk);
    wr(OFS_ALIGN_STATUS, 8'h80);
    waitIrq(1'b1);
    check({6'h00, syncRequestOutA_n, syncRequestOutB_n}, 8'h03);
    $display("test sync_losses done");
    reportAndStop();
  end
endmodule
